// *** include/sdram_decode_pkg.sv ***
package sdram_decode_pkg;
  // Register byte offsets on the plain register port.
  localparam logic [7:0] OFF_MASK0    = 8'h00;
  localparam logic [7:0] OFF_MASK1    = 8'h04;
  localparam logic [7:0] OFF_CFG0     = 8'h08;
  localparam logic [7:0] OFF_CFG1     = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_STATE    = 8'h18;
  // Block mask register fields.
  localparam int unsigned BAM_LSB   = 18;
  localparam int unsigned WPROT_BIT = 8;
  localparam int unsigned ATM_LSB   = 1;
  localparam int unsigned VALID_BIT = 0;
  localparam logic [31:0] MASK_WR_BITS = 32'hFFFC_017F;
  localparam logic [31:0] MASK_RST     = 32'h0000_0000;
  // Access class positions inside the six-bit access type field.
  localparam int unsigned CLS_UDATA = 0;
  localparam int unsigned CLS_UCODE = 1;
  localparam int unsigned CLS_SDATA = 2;
  localparam int unsigned CLS_SCODE = 3;
  localparam int unsigned CLS_ALT   = 4;
  localparam int unsigned CLS_CPU   = 5;
  // Block configuration register fields.
  localparam int unsigned BASE_LSB = 18;
  localparam int unsigned COLS_LSB = 12;
  localparam int unsigned PSEL_LSB = 4;
  localparam int unsigned PM_BIT   = 2;
  localparam logic [31:0] CFG_WR_BITS = 32'hFFFC_7034;
  localparam logic [31:0] CFG_RST     = 32'h0000_0000;
  localparam logic [1:0]  PSEL_32 = 2'h0;
  localparam logic [1:0]  PSEL_8  = 2'h1;
  // Interrupt events.
  localparam int unsigned EV_ADDR_EXC = 0;
  localparam int unsigned EV_EXT_CYC  = 1;
  localparam int unsigned EV_W        = 2;
  localparam logic [1:0]  IRQ_RST     = 2'h0;
  // SDRAM address pins and column line base count.
  localparam int unsigned SD_AW     = 23;
  localparam int unsigned COLS_BASE = 8;
  localparam int unsigned ROW_LOW   = 9;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ROW  = 2'h1,
    ST_COL  = 2'h3
  } phase_t;

  // Word address shift for a port size code: 8-bit 0, 16-bit 1, 32-bit 2.
  function automatic int unsigned shift_of(input logic [1:0] psel);
    if (psel == PSEL_8) begin
      return 0;
    end
    if (psel == PSEL_32) begin
      return 2;
    end
    return 1;
  endfunction
endpackage

// *** include/decode_if.sv ***
`timescale 1ns/1ps
interface blk_if;
  logic [31:0] addr;
  logic [5:0]  cls;
  logic [31:0] mask;
  logic [31:0] cfg;
  logic        hit;
  logic        wprot;
  modport top (output addr, cls, mask, cfg, input hit, wprot);
  modport dec (input addr, cls, mask, cfg, output hit, wprot);
endinterface

interface mux_if;
  logic [31:0] addr;
  logic [1:0]  psel;
  logic [2:0]  cols;
  logic [22:0] row;
  logic [22:0] col;
  modport top (output addr, psel, cols, input row, col);
  modport mux (input addr, psel, cols, output row, col);
endinterface

// *** hw/block_hit_decode.sv ***
`timescale 1ns/1ps
module block_hit_decode (
  // Access and block settings
  blk_if.dec b
);
  logic addr_ok;
  logic cls_ok;

  // A set mask bit takes that address bit out of the compare.
  assign addr_ok = (((b.addr ^ b.cfg) & ~b.mask) >> sdram_decode_pkg::BAM_LSB) == 32'h0;
  assign cls_ok  = (b.cls & b.mask[sdram_decode_pkg::ATM_LSB +: 6]) == 6'h00;
  assign b.hit   = b.mask[sdram_decode_pkg::VALID_BIT] & addr_ok & cls_ok;
  assign b.wprot = b.mask[sdram_decode_pkg::WPROT_BIT];
endmodule

// *** hw/sdram_addr_mux.sv ***
`timescale 1ns/1ps
module sdram_addr_mux (
  // Address and block geometry
  mux_if.mux m
);
  // Row phase: low row bits count down, then the upper bits that the
  // column phase has not taken, in rising order.
  always_comb begin
    int unsigned s;
    int unsigned nlow;
    int unsigned k;
    int unsigned xb;
    int unsigned p;
    s    = sdram_decode_pkg::shift_of(m.psel);
    nlow = sdram_decode_pkg::ROW_LOW - s;
    k    = 0;
    if (32'(m.cols) + sdram_decode_pkg::COLS_BASE > nlow) begin
      k = 32'(m.cols) + sdram_decode_pkg::COLS_BASE - nlow;
    end
    xb    = 18 - s;
    p     = nlow;
    m.row = 23'h0;
    m.col = 23'h0;
    for (int i = 0; i < 9; i++) begin
      if (i < nlow) begin
        m.row[i] = m.addr[17 - s - i];
        m.col[i] = m.addr[s + i];
      end
    end
    for (int j = 0; j < 6; j++) begin
      if (j < k) begin
        m.col[nlow + j] = m.addr[xb + 2 * j];
      end
    end
    for (int b = 16; b < 32; b++) begin
      if (b >= xb && !(((b - xb) % 2 == 0) && ((b - xb) / 2 < k)) &&
          p < sdram_decode_pkg::SD_AW) begin
        m.row[p] = m.addr[b];
        p = p + 1;
      end
    end
  end
endmodule

// *** hw/sdram_decode_top.sv ***
`timescale 1ns/1ps
module sdram_decode_top (
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  // Register port
  input  wire logic [7:0]  I_REG_ADDR,
  input  wire logic [31:0] I_REG_WDATA,
  input  wire logic        I_REG_WR,
  input  wire logic        I_REG_RD,
  output logic      [31:0] O_REG_RDATA,
  // Access request from the core bus
  input  wire logic        I_ACC_VALID,
  input  wire logic [31:0] I_ACC_ADDR,
  input  wire logic        I_ACC_WRITE,
  input  wire logic        I_ACC_CPU_SPACE,
  input  wire logic        I_ACC_ALT_MASTER,
  input  wire logic        I_ACC_SUPER,
  input  wire logic        I_ACC_CODE,
  input  wire logic        I_CS_HIT,
  input  wire logic        I_ACC_DONE,
  // Access result
  output logic             O_BUSY,
  output logic             O_HIT,
  output logic             O_HIT_BLK,
  output logic [1:0]       O_PORT_SIZE,
  output logic             O_PAGE_MODE,
  output logic             O_ADDR_EXC,
  output logic             O_EXT_CYCLE,
  // SDRAM pins
  output logic [22:0]      O_SD_ADDR,
  output logic             O_SD_RAS_N,
  output logic             O_SD_CAS_N,
  output logic             O_SD_WE_N,
  // Interrupt
  output logic             O_IRQ
);
  // ----------------------------------------------------------------
  // Registers and internal signals
  // ----------------------------------------------------------------
  logic [31:0] mask_r [2];
  logic [31:0] cfg_r [2];
  logic [1:0]  irq_stat_r;
  logic [1:0]  irq_mask_r;
  logic [31:0] rdata_r;
  sdram_decode_pkg::phase_t phase_r;
  sdram_decode_pkg::phase_t phase_nxt;
  logic        row_open_r;
  logic        open_blk_r;
  logic [22:0] open_row_r;
  logic [22:0] col_hold_r;
  logic [22:0] sd_addr_r;
  logic        cas_first_r;
  logic        wr_r;
  logic        hit_r;
  logic        hit_blk_r;
  logic [1:0]  psel_r;
  logic        pm_r;
  logic        exc_r;
  logic        ext_r;
  logic [5:0]  acc_cls;
  logic        acc_take;
  logic        any_hit;
  logic        sel;
  logic        wprot_write;
  logic        dram_go;
  logic        same_row;
  logic        cfg_touch;
  logic [1:0]  ev;

  blk_if b0 ();
  blk_if b1 ();
  mux_if mx ();

  // ----------------------------------------------------------------
  // Access classification
  // ----------------------------------------------------------------
  // CPU space beats alternate master, which beats the privilege split.
  function automatic logic [5:0] classify(input logic cpu, input logic alt,
                                          input logic sup, input logic code);
    logic [5:0] c;
    c = 6'h00;
    if (cpu) begin
      c[sdram_decode_pkg::CLS_CPU] = 1'b1;
    end else if (alt) begin
      c[sdram_decode_pkg::CLS_ALT] = 1'b1;
    end else if (sup && code) begin
      c[sdram_decode_pkg::CLS_SCODE] = 1'b1;
    end else if (sup) begin
      c[sdram_decode_pkg::CLS_SDATA] = 1'b1;
    end else if (code) begin
      c[sdram_decode_pkg::CLS_UCODE] = 1'b1;
    end else begin
      c[sdram_decode_pkg::CLS_UDATA] = 1'b1;
    end
    return c;
  endfunction

  assign acc_cls = classify(I_ACC_CPU_SPACE, I_ACC_ALT_MASTER,
                            I_ACC_SUPER, I_ACC_CODE);

  // ----------------------------------------------------------------
  // Block hit decode
  // ----------------------------------------------------------------
  assign b0.addr = I_ACC_ADDR;
  assign b0.cls  = acc_cls;
  assign b0.mask = mask_r[0];
  assign b0.cfg  = cfg_r[0];
  assign b1.addr = I_ACC_ADDR;
  assign b1.cls  = acc_cls;
  assign b1.mask = mask_r[1];
  assign b1.cfg  = cfg_r[1];

  block_hit_decode u_dec0 (
    .b (b0)
  );

  block_hit_decode u_dec1 (
    .b (b1)
  );

  // Block 0 wins if software programs overlapping windows.
  assign any_hit     = b0.hit | b1.hit;
  assign sel         = ~b0.hit;
  assign acc_take    = I_ACC_VALID & (phase_r == sdram_decode_pkg::ST_IDLE);
  assign wprot_write = any_hit & I_ACC_WRITE & (sel ? b1.wprot : b0.wprot);
  assign dram_go     = acc_take & any_hit & ~wprot_write;

  // ----------------------------------------------------------------
  // Row and column address
  // ----------------------------------------------------------------
  assign mx.addr = I_ACC_ADDR;
  assign mx.psel = cfg_r[sel][sdram_decode_pkg::PSEL_LSB +: 2];
  assign mx.cols = cfg_r[sel][sdram_decode_pkg::COLS_LSB +: 3];

  sdram_addr_mux u_mux (
    .m (mx)
  );

  // An open page only helps when the same block and row come back.
  assign same_row = row_open_r & (open_blk_r == sel) & (open_row_r == mx.row);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  assign cfg_touch = I_REG_WR & (I_REG_ADDR == sdram_decode_pkg::OFF_MASK0 ||
                                 I_REG_ADDR == sdram_decode_pkg::OFF_MASK1 ||
                                 I_REG_ADDR == sdram_decode_pkg::OFF_CFG0 ||
                                 I_REG_ADDR == sdram_decode_pkg::OFF_CFG1);

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      mask_r[0] <= sdram_decode_pkg::MASK_RST;
      mask_r[1] <= sdram_decode_pkg::MASK_RST;
    end else if (I_REG_WR && I_REG_ADDR == sdram_decode_pkg::OFF_MASK0) begin
      mask_r[0] <= I_REG_WDATA & sdram_decode_pkg::MASK_WR_BITS;
    end else if (I_REG_WR && I_REG_ADDR == sdram_decode_pkg::OFF_MASK1) begin
      mask_r[1] <= I_REG_WDATA & sdram_decode_pkg::MASK_WR_BITS;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      cfg_r[0] <= sdram_decode_pkg::CFG_RST;
      cfg_r[1] <= sdram_decode_pkg::CFG_RST;
    end else if (I_REG_WR && I_REG_ADDR == sdram_decode_pkg::OFF_CFG0) begin
      cfg_r[0] <= I_REG_WDATA & sdram_decode_pkg::CFG_WR_BITS;
    end else if (I_REG_WR && I_REG_ADDR == sdram_decode_pkg::OFF_CFG1) begin
      cfg_r[1] <= I_REG_WDATA & sdram_decode_pkg::CFG_WR_BITS;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  assign ev[sdram_decode_pkg::EV_ADDR_EXC] = acc_take & wprot_write & ~I_CS_HIT;
  assign ev[sdram_decode_pkg::EV_EXT_CYC]  = acc_take & wprot_write & I_CS_HIT;

  // A new event in the cycle of its clear still sets the bit.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      irq_stat_r <= sdram_decode_pkg::IRQ_RST;
    end else if (I_REG_WR && I_REG_ADDR == sdram_decode_pkg::OFF_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~I_REG_WDATA[1:0]) | ev;
    end else begin
      irq_stat_r <= irq_stat_r | ev;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      irq_mask_r <= sdram_decode_pkg::IRQ_RST;
    end else if (I_REG_WR && I_REG_ADDR == sdram_decode_pkg::OFF_IRQ_MASK) begin
      irq_mask_r <= I_REG_WDATA[1:0];
    end
  end

  assign O_IRQ = |(irq_stat_r & irq_mask_r);

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      rdata_r <= 32'h0000_0000;
    end else if (I_REG_RD) begin
      unique case (I_REG_ADDR)
        sdram_decode_pkg::OFF_MASK0:    rdata_r <= mask_r[0];
        sdram_decode_pkg::OFF_MASK1:    rdata_r <= mask_r[1];
        sdram_decode_pkg::OFF_CFG0:     rdata_r <= cfg_r[0];
        sdram_decode_pkg::OFF_CFG1:     rdata_r <= cfg_r[1];
        sdram_decode_pkg::OFF_IRQ_STAT: rdata_r <= {30'h0, irq_stat_r};
        sdram_decode_pkg::OFF_IRQ_MASK: rdata_r <= {30'h0, irq_mask_r};
        sdram_decode_pkg::OFF_STATE:    rdata_r <= {26'h0, open_blk_r, row_open_r,
                                                    hit_blk_r, hit_r, phase_r};
        default:                        rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign O_REG_RDATA = rdata_r;

  // ----------------------------------------------------------------
  // SDRAM phase sequence
  // ----------------------------------------------------------------
  always_comb begin
    phase_nxt = phase_r;
    unique case (phase_r)
      sdram_decode_pkg::ST_IDLE: begin
        if (dram_go) begin
          phase_nxt = same_row ? sdram_decode_pkg::ST_COL
                               : sdram_decode_pkg::ST_ROW;
        end
      end
      sdram_decode_pkg::ST_ROW: begin
        phase_nxt = sdram_decode_pkg::ST_COL;
      end
      sdram_decode_pkg::ST_COL: begin
        if (I_ACC_DONE) begin
          phase_nxt = sdram_decode_pkg::ST_IDLE;
        end
      end
      default: begin
        phase_nxt = sdram_decode_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      phase_r <= sdram_decode_pkg::ST_IDLE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // Changing a block's settings closes the page, since the open row may
  // no longer belong to the block that software now describes.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      row_open_r <= 1'b0;
      open_blk_r <= 1'b0;
      open_row_r <= 23'h0;
    end else begin
      if (dram_go) begin
        open_blk_r <= sel;
        open_row_r <= mx.row;
      end
      if (cfg_touch || dram_go) begin
        row_open_r <= 1'b0;
      end else if (phase_r == sdram_decode_pkg::ST_COL && I_ACC_DONE) begin
        row_open_r <= pm_r;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      sd_addr_r  <= 23'h0;
      col_hold_r <= 23'h0;
    end else if (dram_go) begin
      sd_addr_r  <= same_row ? mx.col : mx.row;
      col_hold_r <= mx.col;
    end else if (phase_r == sdram_decode_pkg::ST_ROW) begin
      sd_addr_r <= col_hold_r;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      cas_first_r <= 1'b0;
    end else begin
      cas_first_r <= (phase_nxt == sdram_decode_pkg::ST_COL) &&
                     (phase_r != sdram_decode_pkg::ST_COL);
    end
  end

  // ----------------------------------------------------------------
  // Access result
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      hit_r <= 1'b0;
      exc_r <= 1'b0;
      ext_r <= 1'b0;
    end else begin
      hit_r <= dram_go;
      exc_r <= ev[sdram_decode_pkg::EV_ADDR_EXC];
      ext_r <= ev[sdram_decode_pkg::EV_EXT_CYC];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      hit_blk_r <= 1'b0;
      psel_r    <= sdram_decode_pkg::PSEL_32;
      pm_r      <= 1'b0;
      wr_r      <= 1'b0;
    end else if (dram_go) begin
      hit_blk_r <= sel;
      psel_r    <= mx.psel;
      pm_r      <= cfg_r[sel][sdram_decode_pkg::PM_BIT];
      wr_r      <= I_ACC_WRITE;
    end
  end

  assign O_BUSY      = phase_r != sdram_decode_pkg::ST_IDLE;
  assign O_HIT       = hit_r;
  assign O_HIT_BLK   = hit_blk_r;
  assign O_PORT_SIZE = psel_r;
  assign O_PAGE_MODE = pm_r;
  assign O_ADDR_EXC  = exc_r;
  assign O_EXT_CYCLE = ext_r;
  assign O_SD_ADDR   = sd_addr_r;
  assign O_SD_RAS_N  = ~(phase_r == sdram_decode_pkg::ST_ROW);
  assign O_SD_CAS_N  = ~cas_first_r;
  assign O_SD_WE_N   = ~(cas_first_r & wr_r);
endmodule

// *** verif/sdram_decode_chk.sv ***
`timescale 1ns/1ps
module sdram_decode_chk (
  // Clock and register port
  input wire logic        I_CLK,
  input wire logic        I_RST,
  input wire logic [7:0]  I_REG_ADDR,
  input wire logic        I_REG_WR,
  input wire logic        I_REG_RD,
  input wire logic [31:0] O_REG_RDATA,
  // Access port and SDRAM pins
  input wire logic        I_ACC_VALID,
  input wire logic        I_ACC_WRITE,
  input wire logic        I_CS_HIT,
  input wire logic        I_ACC_DONE,
  input wire logic        O_BUSY,
  input wire logic        O_HIT,
  input wire logic        O_ADDR_EXC,
  input wire logic        O_EXT_CYCLE,
  input wire logic        O_SD_RAS_N,
  input wire logic        O_SD_CAS_N,
  input wire logic        O_SD_WE_N,
  input wire logic        O_IRQ
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);
  // ------
  // Access sequence
  // ------
  sequence open_row;
    O_HIT && !O_SD_RAS_N;
  endsequence
  sequence col_strobe;
    O_SD_RAS_N && !O_SD_CAS_N && O_BUSY;
  endsequence
  a_row_then_col: assert property (open_row |=> col_strobe)
    else $error("column strobe missing after row");
  a_ras_hit: assert property (!O_SD_RAS_N |-> O_HIT && O_BUSY)
    else $error("row strobe without hit");
  a_hit_cause: assert property (O_HIT |-> $past(I_ACC_VALID && !O_BUSY))
    else $error("hit without accepted request");
  a_exc_cause: assert property (O_ADDR_EXC |->
    $past(I_ACC_VALID && I_ACC_WRITE && !I_CS_HIT && !O_BUSY) && !O_HIT)
    else $error("address exception without cause");
  a_ext_cause: assert property (O_EXT_CYCLE |->
    $past(I_ACC_VALID && I_ACC_WRITE && I_CS_HIT && !O_BUSY) && !O_HIT && !O_ADDR_EXC)
    else $error("external cycle without cause");
  a_we_with_cas: assert property (!O_SD_WE_N |-> !O_SD_CAS_N)
    else $error("write enable outside column strobe");
  a_busy_done: assert property (O_BUSY && O_SD_RAS_N && I_ACC_DONE |=> !O_BUSY)
    else $error("busy after done");
  a_busy_hold: assert property (O_BUSY && !I_ACC_DONE |=> O_BUSY)
    else $error("busy dropped early");
  // ------
  // Register port
  // ------
  a_rdata_idle: assert property (!$past(I_REG_RD) |-> O_REG_RDATA == 32'h0000_0000)
    else $error("read data outside read slot");
  a_mask_resv: assert property ($past(I_REG_RD && I_REG_ADDR[7:3] == 5'h00
    && I_REG_ADDR[1:0] == 2'h0) |-> O_REG_RDATA[17:9] == 9'h000 && !O_REG_RDATA[7])
    else $error("reserved mask bits not zero");
  a_irq_cause: assert property ($rose(O_IRQ) |->
    O_ADDR_EXC || O_EXT_CYCLE || $past(I_REG_WR))
    else $error("interrupt without event");
endmodule

bind sdram_decode_top sdram_decode_chk u_chk (.I_CLK(I_CLK), .I_RST(I_RST),
  .I_REG_ADDR(I_REG_ADDR), .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD),
  .O_REG_RDATA(O_REG_RDATA), .I_ACC_VALID(I_ACC_VALID), .I_ACC_WRITE(I_ACC_WRITE),
  .I_CS_HIT(I_CS_HIT), .I_ACC_DONE(I_ACC_DONE), .O_BUSY(O_BUSY), .O_HIT(O_HIT),
  .O_ADDR_EXC(O_ADDR_EXC), .O_EXT_CYCLE(O_EXT_CYCLE), .O_SD_RAS_N(O_SD_RAS_N),
  .O_SD_CAS_N(O_SD_CAS_N), .O_SD_WE_N(O_SD_WE_N), .O_IRQ(O_IRQ));

// *** verif/sdram_dev_model.sv ***
`timescale 1ns/1ps
module sdram_dev_model (
  // Clock and SDRAM pins
  input  wire logic        i_clk,
  input  wire logic [22:0] i_sd_addr,
  input  wire logic        i_ras_n,
  input  wire logic        i_cas_n,
  input  wire logic        i_we_n,
  // Sequencer answer and captured pins
  input  wire logic [3:0]  i_lat,
  output logic             o_done,
  output logic [22:0]      o_row,
  output logic [22:0]      o_col,
  output logic             o_wr,
  output int               o_acts
);
  logic [3:0] cnt_r;
  logic       run_r;

  initial begin
    o_done = 1'b0;
    o_row  = 23'h000000;
    o_col  = 23'h000000;
    o_wr   = 1'b0;
    o_acts = 0;
    cnt_r  = 4'h0;
    run_r  = 1'b0;
  end

  // A slow part holds the column phase open for i_lat extra cycles before retiring it.
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    if (!i_ras_n) begin
      o_row  <= i_sd_addr;
      o_acts <= o_acts + 1;
    end
    if (!i_cas_n) begin
      o_col  <= i_sd_addr;
      o_wr   <= !i_we_n;
      run_r  <= i_lat != 4'h0;
      cnt_r  <= i_lat - 4'h1;
      o_done <= i_lat == 4'h0;
    end else if (run_r) begin
      cnt_r  <= cnt_r - 4'h1;
      run_r  <= cnt_r != 4'h0;
      o_done <= cnt_r == 4'h0;
    end
  end
endmodule

// *** verif/sdram_decode_top_tb.sv ***
`timescale 1ns/1ps
module sdram_decode_top_tb;
  typedef struct packed {
    logic [31:0] a;
    logic [3:0]  at;
    logic        w;
    logic        hit;
    logic        blk;
  } case_t;
  logic        I_CLK = 1'b0, I_RST = 1'b1, I_REG_WR = 1'b0, I_REG_RD = 1'b0;
  logic [7:0]  I_REG_ADDR = 8'h00;
  logic [31:0] I_REG_WDATA = 32'h0000_0000, I_ACC_ADDR = 32'h0000_0000, O_REG_RDATA;
  logic        I_ACC_VALID = 1'b0, I_ACC_WRITE = 1'b0, I_CS_HIT = 1'b0, I_ACC_DONE;
  logic [3:0]  attr = 4'h0, lat = 4'h0;
  logic        O_BUSY, O_HIT, O_HIT_BLK, O_PAGE_MODE, O_ADDR_EXC, O_EXT_CYCLE, wr_seen;
  logic        O_SD_RAS_N, O_SD_CAS_N, O_SD_WE_N, O_IRQ;
  logic [1:0]  O_PORT_SIZE;
  logic [22:0] O_SD_ADDR, row, col;
  logic [2:0]  res;
  int          acts, n0, bad_count = 0, tests_run = 0;
  // Attribute order is cpu space, alternate master, supervisor, code.
  case_t       rows [11] = '{'{32'h4000_1234, 4'h0, 1'b0, 1'b1, 1'b0},
    '{32'h4A04_5678, 4'h0, 1'b0, 1'b1, 1'b0}, '{32'h4100_0000, 4'h0, 1'b0, 1'b0, 1'b0},
    '{32'h4000_0010, 4'h1, 1'b0, 1'b0, 1'b0}, '{32'h4000_0020, 4'h3, 1'b0, 1'b1, 1'b0},
    '{32'h4000_0030, 4'h2, 1'b1, 1'b1, 1'b0}, '{32'h4000_0040, 4'h4, 1'b0, 1'b1, 1'b0},
    '{32'h4000_0050, 4'h8, 1'b0, 1'b1, 1'b0}, '{32'h803C_0000, 4'h8, 1'b0, 1'b0, 1'b1},
    '{32'h803C_0100, 4'h0, 1'b1, 1'b1, 1'b1}, '{32'h8040_0000, 4'h0, 1'b0, 1'b0, 1'b1}};

  sdram_decode_top dut (.I_CLK(I_CLK), .I_RST(I_RST), .I_REG_ADDR(I_REG_ADDR),
    .I_REG_WDATA(I_REG_WDATA), .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD),
    .O_REG_RDATA(O_REG_RDATA), .I_ACC_VALID(I_ACC_VALID), .I_ACC_ADDR(I_ACC_ADDR),
    .I_ACC_WRITE(I_ACC_WRITE), .I_ACC_CPU_SPACE(attr[3]), .I_ACC_ALT_MASTER(attr[2]),
    .I_ACC_SUPER(attr[1]), .I_ACC_CODE(attr[0]), .I_CS_HIT(I_CS_HIT),
    .I_ACC_DONE(I_ACC_DONE), .O_BUSY(O_BUSY), .O_HIT(O_HIT), .O_HIT_BLK(O_HIT_BLK),
    .O_PORT_SIZE(O_PORT_SIZE), .O_PAGE_MODE(O_PAGE_MODE), .O_ADDR_EXC(O_ADDR_EXC),
    .O_EXT_CYCLE(O_EXT_CYCLE), .O_SD_ADDR(O_SD_ADDR), .O_SD_RAS_N(O_SD_RAS_N),
    .O_SD_CAS_N(O_SD_CAS_N), .O_SD_WE_N(O_SD_WE_N), .O_IRQ(O_IRQ));
  sdram_dev_model mem (.i_clk(I_CLK), .i_sd_addr(O_SD_ADDR), .i_ras_n(O_SD_RAS_N),
    .i_cas_n(O_SD_CAS_N), .i_we_n(O_SD_WE_N), .i_lat(lat), .o_done(I_ACC_DONE),
    .o_row(row), .o_col(col), .o_wr(wr_seen), .o_acts(acts));

  always #2 I_CLK = ~I_CLK;

  // ------
  // Helpers
  // ------
  // Row and column pin images; extra column bits sit on every second address bit.
  function automatic logic [45:0] mux_exp(input logic [31:0] a, input int ps, input int c);
    int s, low, n, b;
    logic [22:0] r, cl;
    s = (ps == 1) ? 0 : ((ps == 0) ? 2 : 1);
    low = 9 - s;
    n = c + 8 - low;
    b = 18 - s;
    r = 23'h000000;
    cl = 23'h000000;
    for (int k = 0; k < low; k++) begin
      r[k] = a[17 - s - k];
      cl[k] = a[s + k];
    end
    for (int k = 0; k < n; k++) begin
      cl[low + k] = a[18 - s + 2 * k];
    end
    for (int k = low; k < 23; k++) begin
      if (b - 18 + s < 2 * n && (b - s) % 2 == 0) begin
        b++;
      end
      if (b < 32) begin
        r[k] = a[b];
      end
      b++;
    end
    return {r, cl};
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    I_REG_WR <= 1'b1;
    I_REG_ADDR <= a;
    I_REG_WDATA <= d;
    @(posedge I_CLK);
    I_REG_WR <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge I_CLK);
    I_REG_RD <= 1'b1;
    I_REG_ADDR <= a;
    @(posedge I_CLK);
    I_REG_RD <= 1'b0;
    #1 chk(O_REG_RDATA, exp, "register");
  endtask

  task automatic acc(input logic [31:0] a, input logic [3:0] at, input logic w,
                     input logic cs);
    int n;
    n = 0;
    @(posedge I_CLK);
    I_ACC_VALID <= 1'b1;
    I_ACC_ADDR <= a;
    attr <= at;
    I_ACC_WRITE <= w;
    I_CS_HIT <= cs;
    @(posedge I_CLK);
    I_ACC_VALID <= 1'b0;
    #1 res = {O_HIT, O_ADDR_EXC, O_EXT_CYCLE};
    while (O_BUSY === 1'b1 && n < 40) begin
      @(posedge I_CLK);
      #1 n++;
    end
    chk(O_BUSY, 1'b0, "busy");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ------
  // Sequence
  // ------
  initial begin
    repeat (10) @(posedge I_CLK);
    I_RST <= 1'b0;
    for (int o = 0; o < 32; o += 4) begin
      rd(o[7:0], 32'h0000_0000);
    end
    acc(32'h0000_0000, 4'h0, 1'b0, 1'b0);
    chk(res, 3'h0, "invalid block");
    wr(sdram_decode_pkg::OFF_CFG0, 32'h4000_1010);
    wr(sdram_decode_pkg::OFF_CFG1, 32'h8000_0004);
    wr(sdram_decode_pkg::OFF_MASK0, 32'h0A04_0005);
    wr(sdram_decode_pkg::OFF_MASK1, 32'h003C_0041);
    rd(sdram_decode_pkg::OFF_MASK0, 32'h0A04_0005);
    foreach (rows[i]) begin
      acc(rows[i].a, rows[i].at, rows[i].w, 1'b0);
      chk(res, {rows[i].hit, 2'b00}, "hit");
      if (rows[i].hit) begin
        chk({O_HIT_BLK, O_PAGE_MODE}, {2{rows[i].blk}}, "block");
        chk(O_PORT_SIZE, {1'b0, !rows[i].blk}, "port size");
        chk({wr_seen, row, col}, {rows[i].w, mux_exp(rows[i].a, !rows[i].blk,
            !rows[i].blk)}, "pins");
      end
    end
    // A kept-open page must not be activated again; a burst-only page must.
    n0 = acts;
    acc(32'h8000_0100, 4'h0, 1'b0, 1'b0);
    lat = 4'h6;
    acc(32'h8000_0100, 4'h0, 1'b0, 1'b0);
    chk(acts - n0, 1, "continuous page");
    rd(sdram_decode_pkg::OFF_STATE, 32'h0000_0038);
    acc(32'h4000_0000, 4'h0, 1'b0, 1'b0);
    acc(32'h4000_0000, 4'h0, 1'b0, 1'b0);
    chk(acts - n0, 3, "burst page");
    for (int p = 0; p < 4; p++) begin
      for (int c = (p == 1) ? 1 : 0; c < 6; c++) begin
        lat = c[3:0];
        wr(sdram_decode_pkg::OFF_CFG0, 32'h4000_0000 | (c << 12) | (p << 4));
        acc(32'h4A07_B6D9, 4'h0, 1'b1, 1'b0);
        chk(O_PORT_SIZE, p[1:0], "port size");
        chk({wr_seen, row, col}, {1'b1, mux_exp(32'h4A07_B6D9, p, c)}, "mux");
      end
    end
    wr(sdram_decode_pkg::OFF_MASK0, 32'h0A04_0105);
    acc(32'h4000_0000, 4'h0, 1'b1, 1'b0);
    chk({res, O_IRQ}, 4'h4, "protected write");
    rd(sdram_decode_pkg::OFF_IRQ_STAT, 32'h0000_0001);
    wr(sdram_decode_pkg::OFF_IRQ_MASK, 32'h0000_0003);
    #1 chk(O_IRQ, 1'b1, "irq");
    acc(32'h4000_0000, 4'h0, 1'b1, 1'b1);
    chk(res, 3'h1, "external cycle");
    acc(32'h4000_0000, 4'h0, 1'b0, 1'b0);
    chk(res, 3'h4, "protected read");
    rd(sdram_decode_pkg::OFF_IRQ_STAT, 32'h0000_0003);
    wr(sdram_decode_pkg::OFF_IRQ_STAT, 32'h0000_0001);
    rd(sdram_decode_pkg::OFF_IRQ_STAT, 32'h0000_0002);
    wr(sdram_decode_pkg::OFF_IRQ_STAT, 32'h0000_0002);
    #1 chk(O_IRQ, 1'b0, "irq clear");
    wr(sdram_decode_pkg::OFF_MASK1, 32'hFFFF_FFFF);
    rd(sdram_decode_pkg::OFF_MASK1, 32'hFFFC_017F);
    wr(sdram_decode_pkg::OFF_CFG1, 32'hFFFF_FFFF);
    rd(sdram_decode_pkg::OFF_CFG1, sdram_decode_pkg::CFG_WR_BITS);
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0000_0000);
    @(posedge I_CLK);
    I_RST <= 1'b1;
    repeat (2) @(posedge I_CLK);
    I_RST <= 1'b0;
    rd(sdram_decode_pkg::OFF_MASK1, 32'h0000_0000);
    acc(32'h8000_0000, 4'h0, 1'b0, 1'b0);
    chk(res, 3'h0, "after reset");
    test_done;
  end

  initial begin
    repeat (20000) @(posedge I_CLK);
    bad_count++;
    test_done;
  end
endmodule
